// file: rtl/sjlc_pkg.sv
// Shared constants for the shift, Johnson and LFSR counter block
package sjlc_pkg;
    localparam int unsigned WIDTH_DEF   = 8;
    localparam int unsigned JOHN_W_DEF  = 3;
    localparam int unsigned LFSR_W_DEF  = 3;
    // Tap positions are 1-based, tap 1 is the first stage (the msb)
    localparam int unsigned TAP_A_DEF   = 1;
    localparam int unsigned TAP_B_DEF   = 3;
    localparam logic        RESET_BIT   = 1'b0;
    localparam logic        DIR_READ    = 1'b0;
    localparam logic        DIR_WRITE   = 1'b1;
    // Decoding stage 1 alone set jumps over two states: modulo 5 with taps 1,3 and XNOR
    localparam logic [2:0]  SKIP_STATE_DEF = 3'h4;
    localparam logic [1:0]  LFSR_MODE_PLAIN = 2'h0;
    localparam logic [1:0]  LFSR_MODE_SKIP  = 2'h1;
    localparam logic [1:0]  LFSR_MODE_FULL  = 2'h2;
endpackage

// file: rtl/sjlc_stage_if.sv
// Shared clocking and reset for the Johnson and LFSR counter stages
`timescale 1ns/100ps
interface sjlc_stage_if;
    logic clk;
    logic rst_n;
    logic en;
    modport src (output clk, output rst_n, output en);
    modport dst (input clk, input rst_n, input en);
endinterface

// file: rtl/sjlc_johnson.sv
// Johnson counter with two-input state decoder
`timescale 1ns/100ps
module sjlc_johnson #(
    parameter int unsigned N = sjlc_pkg::JOHN_W_DEF
) (
    sjlc_stage_if.dst          st,
    output logic [N-1:0]       count_out,
    output logic [2*N-1:0]     state_hit_out
);
    logic [N-1:0] cnt_q;
    logic [N-1:0] cnt_d;
    logic         fb_inv;

    assign fb_inv = ~cnt_q[0];
    // Bit N-1 is the first stage; sequence 000,100,110,111,011,001
    assign cnt_d  = {fb_inv, cnt_q[N-1:1]};

    always_ff @(posedge st.clk) begin
        if (!st.rst_n) begin
            cnt_q <= {N{sjlc_pkg::RESET_BIT}};
        end else if (st.en) begin
            cnt_q <= cnt_d;
        end
    end

    // States 0 to N fill ones from the top, later states drain them; states 0 and N decode the two end bits, the rest two adjacent bits
    genvar k;
    generate
        for (k = 0; k < 2*N; k++) begin : g_dec
            if (k == 0) begin : g_zero
                assign state_hit_out[k] = ~cnt_q[N-1] & ~cnt_q[0];
            end else if (k < N) begin : g_fill
                assign state_hit_out[k] = cnt_q[N-k] & ~cnt_q[N-k-1];
            end else if (k == N) begin : g_full
                assign state_hit_out[k] = cnt_q[N-1] & cnt_q[0];
            end else begin : g_drain
                assign state_hit_out[k] = ~cnt_q[2*N-k] & cnt_q[2*N-k-1];
            end
        end
    endgenerate

    assign count_out = cnt_q;
endmodule

// file: rtl/sjlc_lfsr.sv
// LFSR counter with XNOR feedback, state skip and full-range option
`timescale 1ns/100ps
module sjlc_lfsr #(
    parameter int unsigned N     = sjlc_pkg::LFSR_W_DEF,
    parameter int unsigned TAP_A = sjlc_pkg::TAP_A_DEF,
    parameter int unsigned TAP_B = sjlc_pkg::TAP_B_DEF,
    parameter logic [N-1:0] SKIP_STATE = N'(sjlc_pkg::SKIP_STATE_DEF)
) (
    sjlc_stage_if.dst          st,
    input  wire logic [1:0]    mode_in,
    output logic [N-1:0]       count_out
);
    // Stage i (1-based) lives in bit N-i, so stage 1 is the msb
    logic [N-1:0] lfsr_q;
    logic [N-1:0] lfsr_d;
    logic         fb_xnor;
    logic         skip_hit;
    logic         stuck_hit;
    logic         fb;

    // XNOR keeps all-zero inside the loop, so reset to zero cannot lock up
    assign fb_xnor   = ~(lfsr_q[N-TAP_A] ^ lfsr_q[N-TAP_B]);
    assign skip_hit  = (mode_in == sjlc_pkg::LFSR_MODE_SKIP) && (lfsr_q == SKIP_STATE);
    // Stuck state for XNOR is all ones; AND of all but the last stage
    assign stuck_hit = (mode_in == sjlc_pkg::LFSR_MODE_FULL) && (&lfsr_q[N-1:1]);
    assign fb        = fb_xnor ^ skip_hit ^ stuck_hit;
    assign lfsr_d    = {fb, lfsr_q[N-1:1]};

    always_ff @(posedge st.clk) begin
        if (!st.rst_n) begin
            lfsr_q <= {N{sjlc_pkg::RESET_BIT}};
        end else if (st.en) begin
            lfsr_q <= lfsr_d;
        end
    end

    assign count_out = lfsr_q;
endmodule

// file: rtl/sjlc_top.sv
// Pad-cell storage register, shift registers, Johnson and LFSR counters
// What this block does
// - The storage register drives its value out while direction is low and takes pin data while high.
// - Internal logic only reads the storage register and never writes it.
// - Each shift stage loads its neighbour's value every enabled clock, and wiring order sets left or right.
// - An n-bit Johnson counter runs through 2n states before repeating.
// - One Johnson bit changes per step, giving 000,100,110,111,011,001 for three bits.
// - The Johnson counter feeds its inverted last stage into its first stage.
// - Reset clears every Johnson stage to zero.
// - Each Johnson state or run of states is decoded glitch-free from just two bits.
// - The LFSR loads its first stage from an XOR or XNOR of tap stages.
// - With good taps the LFSR visits up to 2^n-1 states.
// - Skipping m states gives a modulo of 2^n-1 minus m.
// - A skip decodes the state before the jump and inverts the first-stage feedback then.
// - Reset clears every LFSR stage to zero.
// - The LFSR must not lock in its stuck state, so XNOR feedback is used.
// - Adding the AND of all but the last stuck-state bit makes the LFSR visit all 2^n states.
// - Maximal taps come from the listed pairs per width, such as 1,3 for three bits.
`timescale 1ns/100ps
module sjlc_top #(
    parameter int unsigned WIDTH  = sjlc_pkg::WIDTH_DEF,
    parameter int unsigned JOHN_W = sjlc_pkg::JOHN_W_DEF,
    parameter int unsigned LFSR_W = sjlc_pkg::LFSR_W_DEF,
    parameter int unsigned TAP_A  = sjlc_pkg::TAP_A_DEF,
    parameter int unsigned TAP_B  = sjlc_pkg::TAP_B_DEF,
    parameter logic [LFSR_W-1:0] SKIP_STATE = LFSR_W'(sjlc_pkg::SKIP_STATE_DEF)
) (
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire logic              ce_in,
    input  wire logic              dir_in,
    input  wire logic [WIDTH-1:0]  stor_pad_in,
    output logic      [WIDTH-1:0]  stor_pad_out,
    output logic      [WIDTH-1:0]  stor_pad_oe_n_out,
    output logic      [WIDTH-1:0]  stor_value_out,
    input  wire logic              shl_ser_in,
    input  wire logic              shr_ser_in,
    output logic      [WIDTH-1:0]  shl_out,
    output logic      [WIDTH-1:0]  shr_out,
    output logic      [JOHN_W-1:0]   john_count_out,
    output logic      [2*JOHN_W-1:0] john_state_out,
    input  wire logic [1:0]        lfsr_mode_in,
    output logic      [LFSR_W-1:0] lfsr_count_out
);
    sjlc_stage_if st ();
    assign st.clk   = clk_in;
    assign st.rst_n = rstn_in;
    assign st.en    = ce_in;

    // Pin inputs other than rstn_in and ce_in pass two flops before use; only the pad enable uses raw dir_in
    logic             dir_s1_q;
    logic             dir_s2_q;
    logic [WIDTH-1:0] pad_s1_q;
    logic [WIDTH-1:0] pad_s2_q;
    logic             shl_s1_q;
    logic             shl_s2_q;
    logic             shr_s1_q;
    logic             shr_s2_q;
    logic [1:0]       mode_s1_q;
    logic [1:0]       mode_s2_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            dir_s1_q  <= sjlc_pkg::DIR_READ;
            dir_s2_q  <= sjlc_pkg::DIR_READ;
            pad_s1_q  <= '0;
            pad_s2_q  <= '0;
            shl_s1_q  <= 1'b0;
            shl_s2_q  <= 1'b0;
            shr_s1_q  <= 1'b0;
            shr_s2_q  <= 1'b0;
            mode_s1_q <= sjlc_pkg::LFSR_MODE_PLAIN;
            mode_s2_q <= sjlc_pkg::LFSR_MODE_PLAIN;
        end else if (ce_in) begin
            dir_s1_q  <= dir_in;
            dir_s2_q  <= dir_s1_q;
            pad_s1_q  <= stor_pad_in;
            pad_s2_q  <= pad_s1_q;
            shl_s1_q  <= shl_ser_in;
            shl_s2_q  <= shl_s1_q;
            shr_s1_q  <= shr_ser_in;
            shr_s2_q  <= shr_s1_q;
            mode_s1_q <= lfsr_mode_in;
            mode_s2_q <= mode_s1_q;
        end
    end

    // Storage register: loaded only from the pads, never from inside
    logic [WIDTH-1:0] stor_q;
    logic [WIDTH-1:0] stor_d;
    logic             stor_wr;
    assign stor_wr = (dir_s2_q == sjlc_pkg::DIR_WRITE);
    assign stor_d  = stor_wr ? pad_s2_q : stor_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            stor_q <= {WIDTH{sjlc_pkg::RESET_BIT}};
        end else if (ce_in) begin
            stor_q <= stor_d;
        end
    end

    // Drive the pads in read direction; raw dir avoids contention during sync lag
    logic read_dir;
    assign read_dir          = (dir_in == sjlc_pkg::DIR_READ);
    assign stor_pad_out      = stor_q;
    assign stor_pad_oe_n_out = {WIDTH{~read_dir}};
    assign stor_value_out    = stor_q;

    // Shift registers: left enters at bit 0, right enters at msb
    logic [WIDTH-1:0] shl_q;
    logic [WIDTH-1:0] shr_q;
    logic [WIDTH-1:0] shl_d;
    logic [WIDTH-1:0] shr_d;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_shift
            if (i == 0) begin : g_lo
                assign shl_d[i] = shl_s2_q;
                assign shr_d[i] = shr_q[i+1];
            end else if (i == WIDTH-1) begin : g_hi
                assign shl_d[i] = shl_q[i-1];
                assign shr_d[i] = shr_s2_q;
            end else begin : g_mid
                assign shl_d[i] = shl_q[i-1];
                assign shr_d[i] = shr_q[i+1];
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            shl_q <= {WIDTH{sjlc_pkg::RESET_BIT}};
            shr_q <= {WIDTH{sjlc_pkg::RESET_BIT}};
        end else if (ce_in) begin
            shl_q <= shl_d;
            shr_q <= shr_d;
        end
    end

    assign shl_out = shl_q;
    assign shr_out = shr_q;

    sjlc_johnson #(
        .N (JOHN_W)
    ) u_john (
        .st            (st),
        .count_out     (john_count_out),
        .state_hit_out (john_state_out)
    );

    sjlc_lfsr #(
        .N          (LFSR_W),
        .TAP_A      (TAP_A),
        .TAP_B      (TAP_B),
        .SKIP_STATE (SKIP_STATE)
    ) u_lfsr (
        .st        (st),
        .mode_in   (mode_s2_q),
        .count_out (lfsr_count_out)
    );
endmodule

// file: dv/sjlc_ext_dev.sv
// Outside device model that writes the storage pads and releases them for reads
`timescale 1ns/100ps
module sjlc_ext_dev #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk_in,
    input  wire logic         wr_in,
    input  wire logic [W-1:0] data_in,
    output logic              dir_out,
    output logic [W-1:0]      drv_out
);
    logic [W-1:0] data_q = '0;
    always_ff @(posedge clk_in) begin
        dir_out <= wr_in;
        if (wr_in) begin
            data_q <= data_in;
        end
    end
    // Released pads show inverted data so a stale value cannot pass
    assign drv_out = dir_out ? data_q : ~data_q;
endmodule

// file: dv/sjlc_properties.sv
// Port-level assertions for the counter block
`timescale 1ns/100ps
module sjlc_properties #(
    parameter int unsigned       WIDTH      = 8,
    parameter int unsigned       JOHN_W     = 3,
    parameter int unsigned       LFSR_W     = 3,
    parameter int unsigned       TAP_A      = 1,
    parameter int unsigned       TAP_B      = 3,
    parameter logic [LFSR_W-1:0] SKIP_STATE = '0
) (
    input wire logic [0:0]          clk_in,
    input wire logic                rstn_in,
    input wire logic                ce_in,
    input wire logic                dir_in,
    input wire logic [WIDTH-1:0]    stor_pad_in,
    input wire logic [WIDTH-1:0]    stor_pad_oe_n_out,
    input wire logic [WIDTH-1:0]    stor_value_out,
    input wire logic [WIDTH-1:0]    shl_out,
    input wire logic [JOHN_W-1:0]   john_count_out,
    input wire logic [2*JOHN_W-1:0] john_state_out,
    input wire logic [1:0]          lfsr_mode_in,
    input wire logic [LFSR_W-1:0]   lfsr_count_out
);
    function automatic logic [LFSR_W-1:0] nxt(logic [LFSR_W-1:0] q, logic [1:0] m);
        logic fb;
        fb = ~(q[LFSR_W-TAP_A] ^ q[LFSR_W-TAP_B]);
        if (m == sjlc_pkg::LFSR_MODE_SKIP && q == SKIP_STATE) fb = ~fb;
        if (m == sjlc_pkg::LFSR_MODE_FULL) fb = fb ^ (&q[LFSR_W-1:1]);
        return {fb, q[LFSR_W-1:1]};
    endfunction
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    sequence s_write;
        ce_in && dir_in ##1 ce_in [*2];
    endsequence
    sequence s_mode(logic [1:0] m);
        (ce_in && lfsr_mode_in == m) [*3];
    endsequence
    property p_lfsr(logic [1:0] m);
        s_mode(m) |=> lfsr_count_out == nxt($past(lfsr_count_out), m);
    endproperty
    a_oe_dir: assert property (stor_pad_oe_n_out == {WIDTH{dir_in}})
        else $error("pad enable wrong");
    a_store_take: assert property (s_write |=> stor_value_out == $past(stor_pad_in, 3))
        else $error("store value wrong");
    a_shl_step: assert property (ce_in |=> shl_out[WIDTH-1:1] == $past(shl_out[WIDTH-2:0]))
        else $error("left shift wrong");
    a_john_step: assert property (ce_in |=> john_count_out ==
        {~$past(john_count_out[0]), $past(john_count_out[JOHN_W-1:1])}) else $error("johnson step");
    a_john_decode: assert property ($onehot(john_state_out) &&
        john_state_out[0] == (john_count_out == '0)) else $error("johnson decode");
    a_clear_all: assert property (rstn_in && !$past(rstn_in) && $past(ce_in) |->
        john_count_out == '0 && lfsr_count_out == '0) else $error("reset clear");
    a_lfsr_plain: assert property (p_lfsr(sjlc_pkg::LFSR_MODE_PLAIN))
        else $error("plain step");
    a_lfsr_skip: assert property (p_lfsr(sjlc_pkg::LFSR_MODE_SKIP))
        else $error("skip step");
    a_lfsr_full: assert property (p_lfsr(sjlc_pkg::LFSR_MODE_FULL))
        else $error("full step");
endmodule
bind sjlc_top sjlc_properties #(.WIDTH(WIDTH), .JOHN_W(JOHN_W), .LFSR_W(LFSR_W), .TAP_A(TAP_A),
    .TAP_B(TAP_B), .SKIP_STATE(SKIP_STATE)) u_chk (.clk_in, .rstn_in, .ce_in, .dir_in,
    .stor_pad_in, .stor_pad_oe_n_out, .stor_value_out, .shl_out, .john_count_out,
    .john_state_out, .lfsr_mode_in, .lfsr_count_out);

// file: dv/test_shift_johnson_lfsr_counters.sv
// Self-checking bench for the shift, Johnson and LFSR counter block
`timescale 1ns/100ps
module test_shift_johnson_lfsr_counters;
    localparam logic [17:0] JSEQ = {3'h1, 3'h3, 3'h7, 3'h6, 3'h4, 3'h0};
    logic       clk_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic       ce_in = 1'b1;
    logic       shl_ser_in = 1'b0;
    logic       shr_ser_in = 1'b0;
    logic [1:0] lfsr_mode_in = 2'h0;
    logic       wr = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic       dir_in;
    logic [7:0] stor_pad_in, stor_pad_out, stor_pad_oe_n_out, stor_value_out, drv, shl_out, shr_out;
    logic [2:0] john_count_out, lfsr_count_out;
    logic [5:0] john_state_out;
    int         fail_count = 0;
    int         checked = 0;
    int         n;
    // Each pad carries whichever party has its driver on
    assign stor_pad_in = (stor_pad_oe_n_out & drv) | (~stor_pad_oe_n_out & stor_pad_out);
    sjlc_top DUT (.clk_in, .rstn_in, .ce_in, .dir_in, .stor_pad_in, .stor_pad_out,
        .stor_pad_oe_n_out, .stor_value_out, .shl_ser_in, .shr_ser_in, .shl_out, .shr_out,
        .john_count_out, .john_state_out, .lfsr_mode_in, .lfsr_count_out);
    sjlc_ext_dev #(.W(8)) ext (.clk_in, .wr_in(wr), .data_in(wr_data), .dir_out(dir_in),
        .drv_out(drv));
    always #4 clk_in = ~clk_in;
    task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task automatic rst();
        @(posedge clk_in) rstn_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        #1;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_john();
        cmp("clear", 16'h0, {john_count_out, lfsr_count_out, shl_out});
        for (int k = 1; k < 8; k++) begin
            tick(1);
            cmp("john", JSEQ[3*(k%6) +: 3], john_count_out);
            cmp("decode", 6'h01 << (k % 6), john_state_out);
        end
        @(posedge clk_in) ce_in <= 1'b0;
        tick(1);
        cmp("frozen", JSEQ[6 +: 3], john_count_out);
        @(posedge clk_in) ce_in <= 1'b1;
        $display("johnson test done");
    endtask
    task automatic t_shift();
        @(posedge clk_in) {shl_ser_in, shr_ser_in} <= 2'h3;
        @(posedge clk_in) {shl_ser_in, shr_ser_in} <= 2'h0;
        tick(4);
        cmp("left", 8'h04, shl_out);
        cmp("right", 8'h20, shr_out);
        $display("shift test done");
    endtask
    task automatic t_store();
        @(posedge clk_in) {wr, wr_data} <= {1'b1, 8'hA5};
        tick(5);
        cmp("stored", 8'hA5, stor_value_out);
        cmp("released", 8'hFF, stor_pad_oe_n_out);
        @(posedge clk_in) wr_data <= 8'h5A;
        tick(4);
        cmp("stored", 8'h5A, stor_value_out);
        @(posedge clk_in) wr <= 1'b0;
        tick(2);
        cmp("enable", 8'h00, stor_pad_oe_n_out);
        cmp("readback", 8'h5A, stor_pad_in);
        $display("store test done");
    endtask
    task automatic t_lfsr(logic [1:0] m, int p);
        @(posedge clk_in) lfsr_mode_in <= m;
        rst();
        tick(3);
        n = 0;
        while (lfsr_count_out !== 3'h0 && n < 20) begin
            tick(1);
            n++;
        end
        n = 0;
        do begin
            tick(1);
            n++;
        end while (lfsr_count_out !== 3'h0 && n < 20);
        cmp("period", p, n);
        $display("lfsr mode %0d test done", m);
    endtask
    initial begin
        rst();
        t_john();
        t_shift();
        t_store();
        t_lfsr(sjlc_pkg::LFSR_MODE_PLAIN, 7);
        // Decoding stage 1 alone bypasses two states of the seven
        t_lfsr(sjlc_pkg::LFSR_MODE_SKIP, 5);
        t_lfsr(sjlc_pkg::LFSR_MODE_FULL, 8);
        give_verdict();
    end
    initial begin
        repeat (2000) @(posedge clk_in);
        fail_count++;
        give_verdict();
    end
endmodule
